// file: shared/rcc_pkg.sv
// Package for the reset and configuration controller: map, fields, reset values, types
package rcc_pkg;

   // ----------------------------------------------------------------
   // Register map (printed index, byte address is four times it)
   // ----------------------------------------------------------------
   localparam logic [5:0] RCC_CFG_INDEX = 6'h3F;
   localparam logic [5:0] RCC_STAT_INDEX = 6'h30;
   localparam logic [5:0] RCC_NV_INDEX = 6'h31;

   // ----------------------------------------------------------------
   // Configuration byte fields and values
   // ----------------------------------------------------------------
   localparam int RCC_BIT_AUX_CLK = 5;
   localparam int RCC_BIT_PULLUP = 4;
   localparam int RCC_BIT_SECURITY = 3;
   localparam int RCC_BIT_WATCHDOG = 2;
   localparam int RCC_BIT_NV_MAP = 0;
   localparam logic [7:0] RCC_CFG_ONES = 8'hC2;
   localparam logic [7:0] RCC_CFG_RESET = 8'hFF;
   localparam logic [7:0] RCC_NV_POWER_UP = 8'hFF;

   // ----------------------------------------------------------------
   // Reset vectors and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] RCC_VEC_NORMAL_HI = 8'hFF;
   localparam logic [7:0] RCC_VEC_SPECIAL_HI = 8'hBF;
   localparam logic [7:0] RCC_VEC_POWER_LO = 8'hFE;
   localparam logic [7:0] RCC_VEC_CLOCK_LO = 8'hFC;
   localparam logic [7:0] RCC_VEC_WDOG_LO = 8'hFA;
   localparam int RCC_FETCH_CYCLES = 3;
   localparam int RCC_CLK_PERIOD_NS = 10;
   localparam int RCC_HOLD_NS = 160;
   localparam int RCC_HOLD_CYCLES = (RCC_HOLD_NS + RCC_CLK_PERIOD_NS - 1) / RCC_CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Peripheral start-up values
   // ----------------------------------------------------------------
   localparam logic [7:0] RCC_MAP_BASE_RESET = 8'h00;
   localparam logic [15:0] RCC_REG_END = 16'h009F;
   localparam logic [15:0] RCC_RAM_END = 16'h039F;
   localparam logic [15:0] RCC_RAM_BYTES = 16'h0300;
   localparam logic [15:0] RCC_NV_START = 16'h0D80;
   localparam logic [15:0] RCC_NV_END = 16'h0FFF;
   localparam logic [15:0] RCC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] RCC_COMPARE_RESET = 16'hFFFF;
   localparam logic [15:0] RCC_BAUD_RESET = 16'h0004;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RCC_CAUSE_NONE = 2'b00,
      RCC_CAUSE_POWER_PIN = 2'b01,
      RCC_CAUSE_CLOCK_FAIL = 2'b10,
      RCC_CAUSE_WATCHDOG = 2'b11
   } rcc_cause_e;

   typedef enum logic [2:0] {
      RCC_ST_POWER = 3'b000,
      RCC_ST_LOAD = 3'b001,
      RCC_ST_HOLD = 3'b010,
      RCC_ST_FETCH = 3'b011,
      RCC_ST_RUN = 3'b100
   } rcc_state_e;

   // Forced start-up state handed to the core and the peripherals
   typedef struct packed {
      logic xirq_mask;
      logic irq_mask;
      logic stop_inhibit;
      logic [7:0] map_base;
      logic [15:0] reg_end;
      logic [15:0] ram_end;
      logic [15:0] nv_start;
      logic [15:0] nv_end;
      logic ports_to_bus;
      logic [15:0] t1_count;
      logic [1:0] t1_prescale;
      logic [15:0] t1_compare;
      logic [7:0] compare_one_pin_mask;
      logic [7:0] timer_pin_action_register;
      logic [7:0] capture_edges;
      logic [8:0] t1_flags;
      logic [8:0] t1_masks;
      logic shared_channel_select;
      logic [1:0] channel_five_pin_action;
      logic [15:0] t23_count;
      logic ext_clock_select_a;
      logic ext_clock_select_b;
      logic [15:0] t23_compare;
      logic [7:0] second_timer_flags;
      logic [7:0] third_timer_flags;
      logic [7:0] second_timer_masks;
      logic [7:0] third_timer_masks;
      logic channel_four_select;
      logic [1:0] channel_four_pin_action;
      logic periodic_interrupt_flag;
      logic periodic_irq_enable;
      logic [1:0] periodic_rate;
      logic [7:0] pulse_unit_control_register;
      logic watchdog_enable;
      logic [1:0] watchdog_rate;
      logic [15:0] serial_baud;
      logic serial_nine_bit;
      logic [7:0] serial_control;
      logic transmit_holding_empty;
      logic transmit_complete_flag;
      logic [6:0] serial_rx_flags;
   } rcc_periph_init_s;

endpackage : rcc_pkg

// file: verilog/rcc_reset_config_controller.sv
// Reset sequencer and configuration latch with its Avalon-MM register slave
// Notes on behaviour
// - Configuration bits seven, six and one always read as one.
// - Writes reach the nonvolatile byte; reads and behaviour use working latches.
// - Latches copy the nonvolatile byte each reset; new value visible after reset.
// - Special mode writes latches directly; normal mode waits for next reset.
// - Bit five drives the auxiliary clock out on its pin, else pin off.
// - Bit four enables pull-up assignment; clear forces all pull-ups off.
// - Bit three set turns security off; clear turns it on.
// - Bit two set disables watchdog; clear lets timeout force a reset.
// - Bit zero puts nonvolatile memory in the map; clear removes it.
// - Vector by cause and mode: FFFE, FFFC, FFFA or BF equivalents.
// - Core fetches restart vector over three cycles, then runs.
// - Reset sets both interrupt masks and stop-inhibit; other core state undefined.
// - Map base cleared; registers end at 009F, working memory at 039F.
// - Nonvolatile memory placed from 0D80 through 0FFF after reset.
// - Expanded modes give port pins to bus; single-chip makes all inputs.
// - First timer count, prescaler cleared; compares FFFF; pins, edges, flags, masks off.
// - Shared channel becomes compare five with no pin action.
// - Second, third timers cleared, internal clock, compares FFFF, flags, masks clear.
// - Periodic interrupt flag cleared, interrupt masked, rate bits cleared.
// - Pulse counting unit disabled, its pin a general input.
// - Watchdog enable follows latched disable bit; shortest timeout rate.
// - Serial baud 0004, 8-bit characters, interrupts masked, all functions off.
// - Simultaneous sources served power-on or pin, then clock, then watchdog; here a clock request in the power-on cycle wins over power-on.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns

module rcc_reset_config_controller
   import rcc_pkg::*;
#(
   parameter int HOLD_CYCLES = RCC_HOLD_CYCLES,
   parameter logic [7:0] NV_POWER_UP = RCC_NV_POWER_UP
) (
   // Clock and power-on reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Reset sources and mode straps
   input wire logic reset_pin_req,
   input wire logic clkmon_fail_req,
   input wire logic wdog_timeout_req,
   input wire logic special_mode_flag,
   input wire logic expanded_mode,
   // Avalon-MM register slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Core start-up
   output logic core_reset,
   output logic vector_fetch,
   output logic [15:0] reset_vector_addr,
   output logic core_run,
   // Peripheral start-up
   output logic periph_reset,
   output rcc_periph_init_s periph_init,
   // Configuration effects
   input wire logic auxiliary_clock,
   input wire logic [7:0] pullup_assignment_register,
   output logic aux_clock_output_pin,
   output logic aux_clock_output_pin_oe,
   output logic [7:0] pullup_enable,
   output logic security_active,
   output logic nv_memory_map_enable
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : g_bad_hold
      $error("HOLD_CYCLES must lie between 1 and 255");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rcc_state_e fsm;
      rcc_cause_e cause;
      logic [7:0] cnt;
      logic [7:0] cfg;
      logic [7:0] nv;
      logic special;
      logic expanded;
      logic [15:0] vector;
      rcc_periph_init_s periph;
      logic ack;
      logic [31:0] readdata;
      logic aux_out;
      logic [7:0] pullups;
   } rcc_state_s;

   rcc_state_s st;
   rcc_state_s next_st;
   rcc_periph_init_s init_val;
   logic wdog_live;
   logic req_any;
   logic bus_req;
   logic cfg_hit;
   logic stat_hit;
   logic nv_hit;

   // Register decode, shared by the read and write paths
   function automatic logic rcc_hit(input logic [7:0] addr, input logic [5:0] index);
      rcc_hit = (addr[7:2] == index) && (addr[1:0] == 2'b00);
   endfunction : rcc_hit

   // Start-up values, watchdog from the latch copy about to be used
   always_comb begin
      init_val = '0;
      init_val.xirq_mask = 1'b1;
      init_val.irq_mask = 1'b1;
      init_val.stop_inhibit = 1'b1;
      init_val.map_base = RCC_MAP_BASE_RESET;
      init_val.reg_end = RCC_REG_END;
      init_val.ram_end = RCC_RAM_END;
      init_val.nv_start = RCC_NV_START;
      init_val.nv_end = RCC_NV_END;
      init_val.ports_to_bus = expanded_mode;
      init_val.t1_count = RCC_COUNT_RESET;
      init_val.t1_compare = RCC_COMPARE_RESET;
      init_val.shared_channel_select = 1'b0;
      init_val.channel_five_pin_action = 2'b00;
      init_val.t23_count = RCC_COUNT_RESET;
      init_val.t23_compare = RCC_COMPARE_RESET;
      init_val.channel_four_select = 1'b0;
      init_val.periodic_interrupt_flag = 1'b0;
      init_val.periodic_irq_enable = 1'b0;
      init_val.pulse_unit_control_register = 8'h00;
      init_val.watchdog_enable = ~st.nv[RCC_BIT_WATCHDOG];
      init_val.watchdog_rate = 2'b00;
      init_val.serial_baud = RCC_BAUD_RESET;
      init_val.serial_nine_bit = 1'b0;
      init_val.serial_control = 8'h00;
      init_val.transmit_holding_empty = 1'b1;
      init_val.transmit_complete_flag = 1'b1;
      init_val.serial_rx_flags = 7'h00;
   end

   // Reset requests; a disabled watchdog cannot force a reset
   assign wdog_live = wdog_timeout_req & ~st.cfg[RCC_BIT_WATCHDOG];
   assign req_any = reset_pin_req | clkmon_fail_req | wdog_live;
   assign bus_req = avs_read | avs_write;
   assign cfg_hit = rcc_hit(avs_address, RCC_CFG_INDEX);
   assign stat_hit = rcc_hit(avs_address, RCC_STAT_INDEX);
   assign nv_hit = rcc_hit(avs_address, RCC_NV_INDEX);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      // Sequencer
      case (st.fsm)
         RCC_ST_POWER: begin
            next_st.cause = RCC_CAUSE_POWER_PIN;
            next_st.fsm = RCC_ST_LOAD;
         end
         RCC_ST_LOAD: begin
            // Latches are refreshed here and by a special-mode write, never from a normal-mode write
            next_st.cfg = st.nv | RCC_CFG_ONES;
            next_st.special = special_mode_flag;
            next_st.expanded = expanded_mode;
            next_st.periph = init_val;
            next_st.vector[15:8] = special_mode_flag ? RCC_VEC_SPECIAL_HI
                                                     : RCC_VEC_NORMAL_HI;
            case (st.cause)
               RCC_CAUSE_CLOCK_FAIL: next_st.vector[7:0] = RCC_VEC_CLOCK_LO;
               RCC_CAUSE_WATCHDOG: next_st.vector[7:0] = RCC_VEC_WDOG_LO;
               default: next_st.vector[7:0] = RCC_VEC_POWER_LO;
            endcase
            next_st.cnt = 8'(HOLD_CYCLES - 1);
            next_st.fsm = RCC_ST_HOLD;
         end
         RCC_ST_HOLD: begin
            if (st.cnt == 8'h00) begin
               next_st.cnt = 8'(RCC_FETCH_CYCLES - 1);
               next_st.fsm = RCC_ST_FETCH;
            end else begin
               next_st.cnt = st.cnt - 8'h01;
            end
         end
         RCC_ST_FETCH: begin
            if (st.cnt == 8'h00) begin
               next_st.fsm = RCC_ST_RUN;
            end else begin
               next_st.cnt = st.cnt - 8'h01;
            end
         end
         RCC_ST_RUN: begin
            next_st.fsm = RCC_ST_RUN;
         end
         default: begin
            next_st.fsm = RCC_ST_POWER;
         end
      endcase
      // A new request restarts the sequence; a held pin keeps it restarting
      if (req_any) begin
         if (reset_pin_req) begin
            next_st.cause = RCC_CAUSE_POWER_PIN;
         end else if (clkmon_fail_req) begin
            next_st.cause = RCC_CAUSE_CLOCK_FAIL;
         end else begin
            next_st.cause = RCC_CAUSE_WATCHDOG;
         end
         next_st.fsm = RCC_ST_LOAD;
      end
      // Bus: answer one cycle after the request is seen
      next_st.ack = bus_req & ~st.ack;
      if (avs_read && !st.ack) begin
         if (cfg_hit) begin
            next_st.readdata = {24'h000000, st.cfg | RCC_CFG_ONES};
         end else if (stat_hit) begin
            next_st.readdata = {24'h000000, (st.fsm == RCC_ST_RUN), st.expanded,
                                st.special, st.fsm, st.cause};
         end else if (nv_hit) begin
            next_st.readdata = {24'h000000, st.nv};
         end else begin
            next_st.readdata = 32'h00000000;
         end
      end
      // Write takes effect at the edge where waitrequest is seen low
      if (avs_write && st.ack && cfg_hit && avs_byteenable[0]) begin
         next_st.nv = avs_writedata[7:0] | RCC_CFG_ONES;
         if (st.special) begin
            next_st.cfg = avs_writedata[7:0] | RCC_CFG_ONES;
         end
      end
      // Pin effects, registered so the pins never glitch on decode
      next_st.aux_out = st.cfg[RCC_BIT_AUX_CLK] & auxiliary_clock;
      next_st.pullups = st.cfg[RCC_BIT_PULLUP] ? pullup_assignment_register
                                               : 8'h00;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.fsm <= RCC_ST_POWER;
         st.cfg <= RCC_CFG_RESET;
         st.nv <= NV_POWER_UP; // Power-up image only, kept across system resets
         st.vector <= {RCC_VEC_NORMAL_HI, RCC_VEC_POWER_LO};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Bus handshake is combinational; data from the state register
   assign avs_waitrequest = bus_req & ~st.ack;
   assign avs_readdata = st.readdata;

   // Core sequencing
   assign core_reset = (st.fsm != RCC_ST_FETCH) && (st.fsm != RCC_ST_RUN);
   assign vector_fetch = (st.fsm == RCC_ST_FETCH);
   assign reset_vector_addr = st.vector;
   assign core_run = (st.fsm == RCC_ST_RUN);
   assign periph_reset = (st.fsm != RCC_ST_RUN);
   assign periph_init = st.periph;

   // Configuration effects from the working latches only
   assign aux_clock_output_pin = st.aux_out;
   assign aux_clock_output_pin_oe = st.cfg[RCC_BIT_AUX_CLK];
   assign pullup_enable = st.pullups;
   assign security_active = ~st.cfg[RCC_BIT_SECURITY];
   assign nv_memory_map_enable = st.cfg[RCC_BIT_NV_MAP];

endmodule : rcc_reset_config_controller

// file: dv/rcc_monitor.sv
// Port-level checks for the reset and configuration controller
`timescale 1ns/1ns

module rcc_monitor
   import rcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Reset request and mode straps
   input wire logic reset_pin_req,
   input wire logic special_mode_flag,
   input wire logic expanded_mode,
   // Register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Core and peripheral start-up
   input wire logic core_reset,
   input wire logic vector_fetch,
   input wire logic [15:0] reset_vector_addr,
   input wire logic core_run,
   input wire rcc_periph_init_s periph_init,
   // Configuration effects
   input wire logic auxiliary_clock,
   input wire logic [7:0] pullup_assignment_register,
   input wire logic aux_clock_output_pin,
   input wire logic aux_clock_output_pin_oe,
   input wire logic [7:0] pullup_enable
);
   // ------------------------------------------------
   // Sequences and assertions, one clock domain
   // ------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Fetch lasts exactly three cycles, then the core runs
   sequence s_fetch;
      vector_fetch [*3] ##1 (!vector_fetch && core_run);
   endsequence
   // The moment the core leaves reset; start-up values must be in place
   sequence s_leave;
      $fell(core_reset);
   endsequence

   a_cfg_ones: assert property (
      avs_read && !avs_waitrequest && avs_address == 8'hFC
      |-> (avs_readdata[7:0] & 8'hC2) == 8'hC2) else $error("fixed config ones lost");
   a_fetch_three: assert property ($rose(vector_fetch) |-> s_fetch)
      else $error("fetch window not three cycles");
   a_vector_page: assert property (
      vector_fetch |-> reset_vector_addr[15:8] == (special_mode_flag ? 8'hBF : 8'hFF))
      else $error("vector page wrong for mode");
   a_core_masks: assert property (
      s_leave |-> periph_init.xirq_mask && periph_init.irq_mask && periph_init.stop_inhibit)
      else $error("core masks not set");
   a_map_reset: assert property (
      s_leave |-> periph_init.map_base == 8'h00 && periph_init.nv_start == 16'h0D80
      && periph_init.nv_end == 16'h0FFF) else $error("memory map start-up wrong");
   a_port_mode: assert property (
      s_leave |-> periph_init.ports_to_bus == expanded_mode) else $error("port mode wrong");
   a_serial_reset: assert property (
      s_leave |-> periph_init.serial_baud == 16'h0004 && !periph_init.serial_nine_bit)
      else $error("serial start-up wrong");
   // Guarded by the past reset so the first edge after release is not judged
   a_aux_follow: assert property (
      $past(rst_n) && $stable(aux_clock_output_pin_oe) |-> aux_clock_output_pin
      == (aux_clock_output_pin_oe && $past(auxiliary_clock))) else $error("aux clock gate");
   a_pullup_gate: assert property (
      $past(rst_n) |-> (pullup_enable & ~$past(pullup_assignment_register)) == 8'h00)
      else $error("pull-up outside assignment");
   a_wait_one: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one cycle");
   a_pin_restart: assert property (reset_pin_req |=> core_reset)
      else $error("pin request not served");
endmodule : rcc_monitor

bind rcc_reset_config_controller rcc_monitor u_monitor (
   .clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_req(reset_pin_req),
   .special_mode_flag(special_mode_flag), .expanded_mode(expanded_mode),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_reset(core_reset),
   .vector_fetch(vector_fetch), .reset_vector_addr(reset_vector_addr), .core_run(core_run),
   .periph_init(periph_init), .auxiliary_clock(auxiliary_clock),
   .pullup_assignment_register(pullup_assignment_register),
   .aux_clock_output_pin(aux_clock_output_pin),
   .aux_clock_output_pin_oe(aux_clock_output_pin_oe), .pullup_enable(pullup_enable)
);

// file: dv/rcc_core_model.sv
// Behavioural model of the core and peripherals facing the controller
`timescale 1ns/1ns

module rcc_core_model
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Start-up handshake from the controller
   input wire logic core_reset,
   input wire logic vector_fetch,
   input wire logic [15:0] reset_vector_addr,
   // Peripheral values feeding the configuration gates
   output logic auxiliary_clock,
   output logic [7:0] pullup_assignment_register,
   // What the core saw during its restart
   output logic [15:0] fetched_vec,
   output logic [7:0] fetch_cycles
);
   // Aux clock toggles each cycle so a stuck gate shows; pull-up register holds a pattern
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         auxiliary_clock <= 1'h0;
         pullup_assignment_register <= 8'hA5;
         fetched_vec <= 16'h0000;
         fetch_cycles <= 8'h00;
      end else begin
         auxiliary_clock <= ~auxiliary_clock;
         if (core_reset) begin
            fetch_cycles <= 8'h00;
         end else if (vector_fetch) begin
            fetch_cycles <= fetch_cycles + 8'h01;
            fetched_vec <= reset_vector_addr;
         end
      end
   end
endmodule : rcc_core_model

// file: dv/tb_reset_config_controller.sv
// Self-checking bench for the reset and configuration controller
`timescale 1ns/1ns

module tb_reset_config_controller
   import rcc_pkg::*;
;
   // ------------------------------------------------
   // Signals, design and core model
   // ------------------------------------------------
   logic clk_sys, rst_n, reset_pin_req, clkmon_fail_req, wdog_timeout_req;
   logic special_mode_flag, expanded_mode, avs_read, avs_write, avs_waitrequest, periph_reset;
   logic core_reset, vector_fetch, core_run, auxiliary_clock, aux_pin, aux_oe, sec_on, nv_on;
   logic [7:0] avs_address, pullup_assignment_register, pullup_enable, fetch_cycles;
   logic [15:0] reset_vector_addr, fetched_vec;
   logic [31:0] avs_writedata, avs_readdata, rd;
   rcc_periph_init_s periph_init;
   int bad_count, compares;

   rcc_reset_config_controller #(.HOLD_CYCLES(2)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_req(reset_pin_req),
      .clkmon_fail_req(clkmon_fail_req), .wdog_timeout_req(wdog_timeout_req),
      .special_mode_flag(special_mode_flag), .expanded_mode(expanded_mode),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_reset(core_reset), .vector_fetch(vector_fetch),
      .reset_vector_addr(reset_vector_addr), .core_run(core_run), .periph_reset(periph_reset),
      .periph_init(periph_init), .auxiliary_clock(auxiliary_clock),
      .pullup_assignment_register(pullup_assignment_register), .aux_clock_output_pin(aux_pin),
      .aux_clock_output_pin_oe(aux_oe), .pullup_enable(pullup_enable),
      .security_active(sec_on), .nv_memory_map_enable(nv_on)
   );
   rcc_core_model u_core (
      .clk_sys(clk_sys), .rst_n(rst_n), .core_reset(core_reset), .vector_fetch(vector_fetch),
      .reset_vector_addr(reset_vector_addr), .auxiliary_clock(auxiliary_clock),
      .pullup_assignment_register(pullup_assignment_register), .fetched_vec(fetched_vec),
      .fetch_cycles(fetch_cycles)
   );

   // Clock at 100 MHz
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic check_init(input rcc_periph_init_s exp);
      compares++;
      if (periph_init !== exp) begin
         bad_count++;
         $display("unexpected start-up state expected %h seen %h", exp, periph_init);
      end
   endtask : check_init

   // Avalon master: request held until the edge at which waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_read <= ~wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) begin
         bad_count++;
         summarize();
      end
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask : bus

   // Wait for the run state, then compare vector, fetch length and start-up values
   task automatic after_seq(input logic [15:0] vec, input logic wd_on);
      int n;
      n = 0;
      while (core_run !== 1'h1 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 200) begin
         bad_count++;
         summarize();
      end
      check("vector", {16'h0000, vec}, {16'h0000, fetched_vec});
      check("fetch cycles", 32'h00000003, {24'h000000, fetch_cycles});
      check("periph reset", 32'h00000000, {31'h00000000, periph_reset});
      check_init('{xirq_mask: 1'h1, irq_mask: 1'h1, stop_inhibit: 1'h1,
         reg_end: 16'h009F, ram_end: 16'h039F, nv_start: 16'h0D80, nv_end: 16'h0FFF,
         ports_to_bus: expanded_mode, t1_compare: 16'hFFFF, t23_compare: 16'hFFFF,
         watchdog_enable: wd_on, serial_baud: 16'h0004, transmit_holding_empty: 1'h1,
         transmit_complete_flag: 1'h1, default: '0});
   endtask : after_seq

   // One-cycle pulse on the chosen sources: pin, clock monitor, watchdog
   task automatic trig(input logic [2:0] src);
      @(posedge clk_sys);
      {reset_pin_req, clkmon_fail_req, wdog_timeout_req} <= src;
      @(posedge clk_sys);
      {reset_pin_req, clkmon_fail_req, wdog_timeout_req} <= 3'h0;
      @(negedge clk_sys);
   endtask : trig

   // Aux enable, pull-ups, security on, memory in map
   task automatic effects(input logic [10:0] exp);
      check("effects", {21'h000000, exp}, {21'h000000, aux_oe, pullup_enable, sec_on, nv_on});
   endtask : effects

   // ------------------------------------------------
   // Test sequence
   // ------------------------------------------------
   initial begin
      rst_n = 1'h0;
      {reset_pin_req, clkmon_fail_req, wdog_timeout_req, special_mode_flag} = 4'h0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      expanded_mode = 1'h1;
      bad_count = 0;
      compares = 0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'h1;
      after_seq(16'hFFFE, 1'h0);
      bus(1'h0, 8'hFC, 8'h00);
      check("config", 32'h000000FF, rd);
      bus(1'h0, 8'hC0, 8'h00);
      check("status", 32'h000000D1, rd);
      effects({1'h1, 8'hA5, 1'h0, 1'h1});
      $display("test power-up done");
      // Normal mode: a write only programs the backing byte
      bus(1'h1, 8'hFC, 8'h00);
      bus(1'h0, 8'hFC, 8'h00);
      check("config", 32'h000000FF, rd);
      bus(1'h0, 8'hC4, 8'h00);
      check("backing byte", 32'h000000C2, rd);
      bus(1'h0, 8'h00, 8'h00);
      check("unmapped", 32'h00000000, rd);
      $display("test programming done");
      // Pin reset in single-chip mode latches the new byte
      expanded_mode <= 1'h0;
      trig(3'h4);
      after_seq(16'hFFFE, 1'h1);
      bus(1'h0, 8'hFC, 8'h00);
      check("config", 32'h000000C2, rd);
      effects({1'h0, 8'h00, 1'h1, 1'h0});
      // Simultaneous sources served in fixed order; watchdog alone gives FFFA
      trig(3'h3);
      after_seq(16'hFFFC, 1'h1);
      trig(3'h1);
      after_seq(16'hFFFA, 1'h1);
      trig(3'h7);
      after_seq(16'hFFFE, 1'h1);
      $display("test sources done");
      // Special mode: latches written directly, disabled watchdog refused
      @(posedge clk_sys);
      special_mode_flag <= 1'h1;
      trig(3'h4);
      after_seq(16'hBFFE, 1'h1);
      bus(1'h1, 8'hFC, 8'hFF);
      bus(1'h0, 8'hFC, 8'h00);
      check("config", 32'h000000FF, rd);
      repeat (3) @(negedge clk_sys);
      effects({1'h1, 8'hA5, 1'h0, 1'h1});
      trig(3'h1);
      check("run kept", 32'h00000001, {31'h00000000, core_run});
      trig(3'h2);
      after_seq(16'hBFFC, 1'h0);
      $display("test special mode done");
      // Power-on reset in mid-run restores the factory byte
      @(posedge clk_sys);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'h1;
      after_seq(16'hBFFE, 1'h0);
      $display("test second power-on done");
      summarize();
   end
endmodule : tb_reset_config_controller
